//--- src/rbp_pkg.sv
// Constants shared by the raster board command port and its function unit.
// Assumes one board clock; all fields are positions in the host bus address
// or data word.
`default_nettype none

package rbp_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W      = 20;  // Decoded memory address bits
  localparam int DATA_W      = 16;  // Bus data word
  localparam int COORD_W     = 10;  // One cursor coordinate
  localparam int FUNC_W      = 8;   // Raster function lookup table
  localparam int WIDTH_W     = 4;   // Operation width field
  localparam int NUM_CURSORS = 4;   // Cursor pairs

  // ****************************************************************
  // Address field positions
  // ****************************************************************
  localparam int BOARD_HI    = 19;  // Board select, top bit
  localparam int BOARD_LO    = 17;  // Board select, low bit
  localparam int UPDATE_BIT  = 16;  // Frame buffer update request
  localparam int OP_HI       = 15;  // Operation code, high bit
  localparam int OP_LO       = 14;  // Operation code, low bit
  localparam int PAIR_HI     = 13;  // Cursor pair select, high bit
  localparam int PAIR_LO     = 12;  // Cursor pair select, low bit
  localparam int XY_BIT      = 11;  // 0 loads x, 1 loads y
  localparam int COORD_HI    = 10;  // Coordinate, high bit
  localparam int COORD_LO    = 1;   // Coordinate, low bit
  localparam int AUX_HI      = 2;   // Auxiliary register number, high
  localparam int AUX_LO      = 1;   // Auxiliary register number, low

  // ****************************************************************
  // Operation codes and auxiliary register numbers
  // ****************************************************************
  localparam logic [1:0] OP_NONE = 2'h0;  // Bus data unused
  localparam logic [1:0] OP_AUX  = 2'h1;  // Auxiliary register write
  localparam logic [1:0] OP_SRC  = 2'h2;  // Load source pixels
  localparam logic [1:0] OP_PAT  = 2'h3;  // Load pattern pixels

  localparam logic [1:0] AUX_FUNC  = 2'h0;  // Raster function select
  localparam logic [1:0] AUX_WIDTH = 2'h1;  // Operation width
  localparam logic [1:0] AUX_CTRL  = 2'h2;  // Board control
  localparam logic [1:0] AUX_IACK  = 2'h3;  // Retrace interrupt ack

  // ****************************************************************
  // Board control fields and reset values
  // ****************************************************************
  localparam int CTRL_LVL_HI = 15;  // Interrupt level, high bit
  localparam int CTRL_LVL_LO = 13;  // Interrupt level, low bit
  localparam int CTRL_LED    = 10;  // Indicator off when set
  localparam int CTRL_VIDEO  = 9;   // Video enable
  localparam int CTRL_IEN    = 8;   // Retrace interrupt enable

  localparam logic [DATA_W-1:0]  CTRL_RST  = 16'h0000;
  localparam logic [FUNC_W-1:0]  FUNC_RST  = 8'h00;
  localparam logic [WIDTH_W-1:0] WIDTH_RST = 4'h0;  // Zero means sixteen
  localparam logic [DATA_W-1:0]  PIX_RST   = 16'h0000;
  localparam logic [COORD_W-1:0] COORD_RST = 10'h000;

endpackage

`default_nettype wire

//--- src/rbp_function_unit.sv
// Raster function unit: combines destination, source and pattern pixels
// through the eight-bit lookup table and builds the write mask.
// Assumes the frame buffer word is left-justified at the cursor x.
`default_nettype none

module rbp_function_unit
  import rbp_pkg::*;
(
  // Operands
  input  wire logic [rbp_pkg::DATA_W-1:0]  dst,
  input  wire logic [rbp_pkg::DATA_W-1:0]  src,
  input  wire logic [rbp_pkg::DATA_W-1:0]  pat,
  // Setup
  input  wire logic [rbp_pkg::FUNC_W-1:0]  func,
  input  wire logic [rbp_pkg::WIDTH_W-1:0] width,
  input  wire logic [3:0]                  x_phase,
  // Results
  output logic      [rbp_pkg::DATA_W-1:0]  result,
  output logic      [rbp_pkg::DATA_W-1:0]  mask
);

  // ****************************************************************
  // Pattern alignment
  // ****************************************************************
  // Pattern repeats on sixteen-pixel boundaries, so rotate it left
  logic [2*DATA_W-1:0] pat_twice;  // Pattern doubled for rotation
  logic [DATA_W-1:0]   pat_al;     // Pattern at the cursor phase
  logic [4:0]          width_n;    // Width as 1..16

  assign pat_twice = {pat, pat};
  assign pat_al    = pat_twice[(2*DATA_W-1) - x_phase -: DATA_W];
  assign width_n   = (width == WIDTH_RST) ? 5'h10 : {1'b0, width};

  // ****************************************************************
  // Per-pixel lookup and mask
  // ****************************************************************
  for (genvar i = 0; i < DATA_W; i++) begin : g_pix
    // Index with pattern most significant, destination least
    assign result[i] = func[{pat_al[i], src[i], dst[i]}];
    // Only the high-order width pixels are significant
    assign mask[i] = (5'(DATA_W - 1 - i) < width_n);
  end

endmodule

`default_nettype wire

//--- src/rbp_command_port.sv
// Host command port of a raster board: decodes address and data of each
// host cycle into one frame buffer command, queues it one deep and runs it.
// Assumes host signals synchronous to clk and a frame buffer that answers
// each request with a one-cycle acknowledge.
`default_nettype none

module rbp_command_port
  import rbp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        ce,
  // Board number strap
  input  wire logic [2:0]                  board_num,
  // Host bus
  input  wire logic                        host_req,
  input  wire logic                        host_write,
  input  wire logic [rbp_pkg::ADDR_W-1:0]  host_addr,
  input  wire logic [rbp_pkg::DATA_W-1:0]  host_wdata,
  output logic                             host_ack,
  output logic      [rbp_pkg::DATA_W-1:0]  host_rdata,
  output logic                             host_rdata_oe,
  // Frame buffer port
  output logic                             fb_req,
  output logic                             fb_we,
  output logic      [rbp_pkg::COORD_W-1:0] fb_x,
  output logic      [rbp_pkg::COORD_W-1:0] fb_y,
  output logic      [rbp_pkg::DATA_W-1:0]  fb_wdata,
  output logic      [rbp_pkg::DATA_W-1:0]  fb_wmask,
  input  wire logic                        fb_ack,
  input  wire logic [rbp_pkg::DATA_W-1:0]  fb_rdata,
  // Board control and retrace interrupt
  input  wire logic                        retrace_start,
  output logic                             retrace_irq,
  output logic      [2:0]                  irq_level,
  output logic                             video_en,
  output logic                             led_off
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [1:0] {
    RBP_IDLE,   // Waiting for a queued command
    RBP_READ,   // Frame buffer read outstanding
    RBP_WRITE   // Frame buffer write outstanding
  } rbp_state_t;

  rbp_state_t          state_reg, state_next;       // Sequencer
  logic                q_vld_reg, q_vld_next;       // Queue entry full
  logic                q_wr_reg, q_wr_next;         // Queued write
  logic [ADDR_W-1:0]   q_addr_reg, q_addr_next;     // Queued address
  logic [DATA_W-1:0]   q_data_reg, q_data_next;     // Queued data
  logic                cur_wr_reg, cur_wr_next;     // Running write
  logic                cur_upd_reg, cur_upd_next;   // Running update
  logic [1:0]          cur_op_reg, cur_op_next;     // Running op code
  logic [1:0]          cur_pair_reg, cur_pair_next; // Running pair
  logic [2:0]          board_reg;                   // Captured strap
  logic [DATA_W-1:0]   src_reg, src_next;           // Source pixels
  logic [DATA_W-1:0]   pat_reg, pat_next;           // Pattern pixels
  logic [DATA_W-1:0]   dst_reg, dst_next;           // Destination
  logic [FUNC_W-1:0]   func_reg, func_next;         // Function select
  logic [WIDTH_W-1:0]  width_reg, width_next;       // Operation width
  logic [DATA_W-1:0]   ctrl_reg, ctrl_next;         // Board control
  logic                pend_reg, pend_next;         // Retrace pending
  logic [COORD_W-1:0]  cx_reg [NUM_CURSORS];        // Cursor x values
  logic [COORD_W-1:0]  cy_reg [NUM_CURSORS];        // Cursor y values
  logic [COORD_W-1:0]  cx_next [NUM_CURSORS];
  logic [COORD_W-1:0]  cy_next [NUM_CURSORS];
  logic                ack_reg, ack_next;           // Bus acknowledge
  logic [DATA_W-1:0]   rdata_reg, rdata_next;       // Bus read data
  logic                oe_reg, oe_next;             // Bus data drive
  logic                fbr_reg, fbr_next;           // Frame buffer req
  logic                fbw_reg, fbw_next;           // Frame buffer we
  logic [COORD_W-1:0]  fbx_reg, fbx_next;           // Frame buffer x
  logic [COORD_W-1:0]  fby_reg, fby_next;           // Frame buffer y
  logic [DATA_W-1:0]   fbd_reg, fbd_next;           // Write data
  logic [DATA_W-1:0]   fbm_reg, fbm_next;           // Write mask
  logic                irq_reg, irq_next;           // Interrupt out
  logic                board_hit;                   // Address is ours
  logic                take;                        // Request taken
  logic [DATA_W-1:0]   rop_result;                  // Raster result
  logic [DATA_W-1:0]   rop_mask;                    // Width mask

  // ****************************************************************
  // Raster function unit
  // ****************************************************************
  rbp_function_unit u_fu (
    .dst     (dst_reg),
    .src     (src_reg),
    .pat     (pat_reg),
    .func    (func_reg),
    .width   (width_reg),
    .x_phase (fbx_reg[3:0]),
    .result  (rop_result),
    .mask    (rop_mask)
  );

  // ****************************************************************
  // Host request acceptance
  // ****************************************************************
  // Board strap caught by clock, never through the reset path
  always_ff @(posedge clk) begin
    if (ce) begin
      board_reg <= board_num;
    end
  end

  assign board_hit = (host_addr[BOARD_HI:BOARD_LO] == board_reg);
  // Held off while the queue is full or the last ack still shows;
  // a read also waits for the sequencer, so that the source register
  // already holds the previous non-pattern read's pixels when it is returned
  assign take = host_req && board_hit && !q_vld_reg && !ack_reg &&
                (host_write || state_reg == RBP_IDLE);

  // Queue and bus answer next values
  always_comb begin
    q_vld_next  = q_vld_reg;
    q_wr_next   = q_wr_reg;
    q_addr_next = q_addr_reg;
    q_data_next = q_data_reg;
    ack_next    = 1'b0;
    rdata_next  = rdata_reg;
    oe_next     = 1'b0;
    if (take) begin
      // Latch the request; host cycle ends without waiting
      q_vld_next  = 1'b1;
      q_wr_next   = host_write;
      q_addr_next = host_addr;
      q_data_next = host_wdata;
      ack_next    = 1'b1;
      oe_next     = !host_write;
      // Source register holds the last source write or non-pattern read's pixels
      if (!host_write) begin
        rdata_next = src_reg;
      end
    end else if (state_reg == RBP_IDLE && q_vld_reg) begin
      // Sequencer drains the entry
      q_vld_next = 1'b0;
    end
  end

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_comb begin
    state_next    = state_reg;
    cur_wr_next   = cur_wr_reg;
    cur_upd_next  = cur_upd_reg;
    cur_op_next   = cur_op_reg;
    cur_pair_next = cur_pair_reg;
    src_next      = src_reg;
    pat_next      = pat_reg;
    dst_next      = dst_reg;
    func_next     = func_reg;
    width_next    = width_reg;
    ctrl_next     = ctrl_reg;
    fbr_next      = 1'b0;
    fbw_next      = fbw_reg;
    fbx_next      = fbx_reg;
    fby_next      = fby_reg;
    fbd_next      = fbd_reg;
    fbm_next      = fbm_reg;
    cx_next       = cx_reg;
    cy_next       = cy_reg;
    // Set wins over acknowledge in the same cycle
    pend_next     = pend_reg;
    case (state_reg)
      RBP_IDLE: begin
        if (q_vld_reg) begin
          cur_wr_next   = q_wr_reg;
          // Update bit counts only on writes
          cur_upd_next  = q_wr_reg && q_addr_reg[UPDATE_BIT];
          cur_op_next   = q_addr_reg[OP_HI:OP_LO];
          cur_pair_next = q_addr_reg[PAIR_HI:PAIR_LO];
          // Exactly one coordinate register changes
          if (q_addr_reg[XY_BIT]) begin
            cy_next[q_addr_reg[PAIR_HI:PAIR_LO]] =
              q_addr_reg[COORD_HI:COORD_LO];
          end else begin
            cx_next[q_addr_reg[PAIR_HI:PAIR_LO]] =
              q_addr_reg[COORD_HI:COORD_LO];
          end
          // Interrupt acknowledge on any access to aux three
          if (q_addr_reg[OP_HI:OP_LO] == OP_AUX &&
              q_addr_reg[AUX_HI:AUX_LO] == AUX_IACK) begin
            pend_next = 1'b0;
          end
          // Register load from bus data, writes only
          if (q_wr_reg) begin
            if (q_addr_reg[OP_HI:OP_LO] == OP_SRC) begin
              src_next = q_data_reg;
            end else if (q_addr_reg[OP_HI:OP_LO] == OP_PAT) begin
              pat_next = q_data_reg;
            end else if (q_addr_reg[OP_HI:OP_LO] == OP_AUX) begin
              case (q_addr_reg[AUX_HI:AUX_LO])
                AUX_FUNC:  func_next  = q_data_reg[FUNC_W-1:0];
                AUX_WIDTH: width_next = q_data_reg[WIDTH_W-1:0];
                AUX_CTRL:  ctrl_next  = q_data_reg;
                default:   ctrl_next  = ctrl_reg;
              endcase
            end
          end
          // Start the frame buffer read at the selected cursor
          fbx_next = q_addr_reg[XY_BIT] ?
                     cx_reg[q_addr_reg[PAIR_HI:PAIR_LO]] :
                     q_addr_reg[COORD_HI:COORD_LO];
          fby_next = q_addr_reg[XY_BIT] ?
                     q_addr_reg[COORD_HI:COORD_LO] :
                     cy_reg[q_addr_reg[PAIR_HI:PAIR_LO]];
          fbr_next   = 1'b1;
          fbw_next   = 1'b0;
          state_next = RBP_READ;
        end
      end
      RBP_READ: begin
        if (fb_ack) begin
          if (cur_wr_reg) begin
            // Destination read always precedes any update
            dst_next = fb_rdata;
            if (cur_upd_reg) begin
              state_next = RBP_WRITE;
            end else begin
              state_next = RBP_IDLE;
            end
          end else begin
            // Read lands in pattern or source, never writes memory
            if (cur_op_reg == OP_PAT) begin
              pat_next = fb_rdata;
            end else begin
              src_next = fb_rdata;
            end
            state_next = RBP_IDLE;
          end
        end else begin
          fbr_next = 1'b1;
        end
      end
      RBP_WRITE: begin
        // Combine after the register load, same command
        fbr_next = !fb_ack && fbr_reg;
        if (!fbw_reg) begin
          fbw_next = 1'b1;
          fbd_next = rop_result;
          fbm_next = rop_mask;
          fbr_next = 1'b1;
        end else if (fb_ack) begin
          fbw_next   = 1'b0;
          state_next = RBP_IDLE;
        end else begin
          fbr_next = 1'b1;
        end
      end
      default: begin
        state_next = RBP_IDLE;
      end
    endcase
    // Retrace start sets pending last so it wins
    if (retrace_start) begin
      pend_next = 1'b1;
    end
    irq_next = pend_next && ctrl_next[CTRL_IEN];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg    <= RBP_IDLE;
      q_vld_reg    <= 1'b0;
      q_wr_reg     <= 1'b0;
      q_addr_reg   <= '0;
      q_data_reg   <= '0;
      cur_wr_reg   <= 1'b0;
      cur_upd_reg  <= 1'b0;
      cur_op_reg   <= OP_NONE;
      cur_pair_reg <= 2'h0;
      src_reg      <= PIX_RST;
      pat_reg      <= PIX_RST;
      dst_reg      <= PIX_RST;
      func_reg     <= FUNC_RST;
      width_reg    <= WIDTH_RST;
      ctrl_reg     <= CTRL_RST;
      pend_reg     <= 1'b0;
      cx_reg       <= '{default: COORD_RST};
      cy_reg       <= '{default: COORD_RST};
      ack_reg      <= 1'b0;
      rdata_reg    <= PIX_RST;
      oe_reg       <= 1'b0;
      fbr_reg      <= 1'b0;
      fbw_reg      <= 1'b0;
      fbx_reg      <= COORD_RST;
      fby_reg      <= COORD_RST;
      fbd_reg      <= PIX_RST;
      fbm_reg      <= PIX_RST;
      irq_reg      <= 1'b0;
    end else if (ce) begin
      state_reg    <= state_next;
      q_vld_reg    <= q_vld_next;
      q_wr_reg     <= q_wr_next;
      q_addr_reg   <= q_addr_next;
      q_data_reg   <= q_data_next;
      cur_wr_reg   <= cur_wr_next;
      cur_upd_reg  <= cur_upd_next;
      cur_op_reg   <= cur_op_next;
      cur_pair_reg <= cur_pair_next;
      src_reg      <= src_next;
      pat_reg      <= pat_next;
      dst_reg      <= dst_next;
      func_reg     <= func_next;
      width_reg    <= width_next;
      ctrl_reg     <= ctrl_next;
      pend_reg     <= pend_next;
      cx_reg       <= cx_next;
      cy_reg       <= cy_next;
      ack_reg      <= ack_next;
      rdata_reg    <= rdata_next;
      oe_reg       <= oe_next;
      fbr_reg      <= fbr_next;
      fbw_reg      <= fbw_next;
      fbx_reg      <= fbx_next;
      fby_reg      <= fby_next;
      fbd_reg      <= fbd_next;
      fbm_reg      <= fbm_next;
      irq_reg      <= irq_next;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign host_ack      = ack_reg;
  assign host_rdata    = rdata_reg;
  assign host_rdata_oe = oe_reg;
  assign fb_req        = fbr_reg;
  assign fb_we         = fbw_reg;
  assign fb_x          = fbx_reg;
  assign fb_y          = fby_reg;
  assign fb_wdata      = fbd_reg;
  assign fb_wmask      = fbm_reg;
  assign retrace_irq   = irq_reg;
  assign irq_level     = ctrl_reg[CTRL_LVL_HI:CTRL_LVL_LO];
  assign video_en      = ctrl_reg[CTRL_VIDEO];
  assign led_off       = ctrl_reg[CTRL_LED];

endmodule

`default_nettype wire

//--- verification/rbp_fb_model.sv
// Frame buffer model for the command port, random answer latency.
// Assumes fb_req is held until fb_ack; one board clock.
`default_nettype none
module rbp_fb_model
  import rbp_pkg::*;
(
  // Clock
  input  wire logic                        clk,
  // Requests from the port
  input  wire logic                        fb_req,
  input  wire logic                        fb_we,
  input  wire logic [rbp_pkg::COORD_W-1:0] fb_x,
  input  wire logic [rbp_pkg::COORD_W-1:0] fb_y,
  input  wire logic [rbp_pkg::DATA_W-1:0]  fb_wdata,
  input  wire logic [rbp_pkg::DATA_W-1:0]  fb_wmask,
  // Answers
  output logic                             fb_ack,
  output logic      [rbp_pkg::DATA_W-1:0]  fb_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];  // Words written so far, keyed by y and x
  int          wait_n;     // Cycles left before the next answer
  logic [15:0] word;       // Current content at fb_x, fb_y
  initial begin
    fb_ack   = 1'b0;
    fb_rdata = 16'h5a5a;
    wait_n   = 1;
  end
  // One answer per request; data toggles except in a cycle that answers a read
  always @(posedge clk) begin
    word = mem.exists({fb_y, fb_x}) ? mem[{fb_y, fb_x}]
                                    : {fb_y[5:0], fb_x} ^ 16'ha5c3;
    fb_ack   <= 1'b0;
    fb_rdata <= ~fb_rdata;
    if (fb_req && !fb_ack) begin
      if (wait_n > 0) begin
        wait_n--;
      end else begin
        fb_ack <= 1'b1;
        wait_n = $urandom_range(3);
        if (fb_we) begin
          mem[{fb_y, fb_x}] = (word & ~fb_wmask) | (fb_wdata & fb_wmask);
        end else begin
          fb_rdata <= word;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/rbp_command_port_chk.sv
// Concurrent checks on the command port pins, bound to every instance.
// Assumes one clock, srst synchronous active high, ce held high.
`default_nettype none
module rbp_command_port_chk
  import rbp_pkg::*;
(
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic                        ce,
  // Host bus
  input wire logic [2:0]                  board_num,
  input wire logic                        host_req,
  input wire logic                        host_write,
  input wire logic [rbp_pkg::ADDR_W-1:0]  host_addr,
  input wire logic                        host_ack,
  input wire logic [rbp_pkg::DATA_W-1:0]  host_rdata,
  input wire logic                        host_rdata_oe,
  // Frame buffer and board control
  input wire logic                        fb_req,
  input wire logic                        fb_we,
  input wire logic [rbp_pkg::COORD_W-1:0] fb_x,
  input wire logic [rbp_pkg::DATA_W-1:0]  fb_wmask,
  input wire logic                        fb_ack,
  input wire logic [2:0]                  irq_level,
  input wire logic                        video_en,
  input wire logic                        led_off
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic rd_done_reg;   // Destination read seen since the last write
  logic rd_done_next;
  // Track whether the last finished access was a read
  always_comb begin
    rd_done_next = rd_done_reg;
    if (fb_req && fb_ack) rd_done_next = !fb_we;
    if (srst) rd_done_next = 1'b0;
  end
  always_ff @(posedge clk) rd_done_reg <= rd_done_next;
  a_ack_single: assert property (
    host_ack && ce |=> !host_ack) else $error("host_ack held");
  a_board_sel: assert property (
    host_ack |-> $past(host_req && host_addr[19:17] == board_num))
    else $error("ack for another board");
  a_oe_on_read: assert property (
    host_rdata_oe |-> host_ack && !$past(host_write))
    else $error("data driven outside a read ack");
  a_rdata_hold: assert property (
    !host_rdata_oe && !$past(srst) |-> $stable(host_rdata))
    else $error("read data moved between reads");
  a_fb_hold: assert property (
    fb_req && !fb_ack |=> fb_req && $stable(fb_we) && $stable(fb_x))
    else $error("frame buffer request dropped early");
  a_mask_shape: assert property (
    fb_req && fb_we |-> fb_wmask[15]
      && (((~fb_wmask) + 16'h1) & ~fb_wmask) == 16'h0)
    else $error("write mask not high-order");
  a_read_first: assert property (
    fb_req && fb_we |-> rd_done_reg) else $error("write without read");
  a_ctrl_clear: assert property (
    $past(srst) |-> irq_level == 3'h0 && !video_en && !led_off)
    else $error("control not cleared by reset");
endmodule

bind rbp_command_port rbp_command_port_chk u_chk (
  .clk, .srst, .ce, .board_num, .host_req, .host_write, .host_addr,
  .host_ack, .host_rdata, .host_rdata_oe, .fb_req, .fb_we, .fb_x,
  .fb_wmask, .fb_ack, .irq_level, .video_en, .led_off
);
`default_nettype wire

//--- verification/raster_board_bus_command_port_test.sv
// Testbench for the command port: host tasks, frame buffer model.
// Assumes rbp_pkg, the design and the checker are compiled first.
`default_nettype none
module raster_board_bus_command_port_test;
  import rbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] BRD = 3'h5;  // Strapped board number
  logic clk, srst, ce, host_req, host_write, host_ack, host_rdata_oe;
  logic fb_req, fb_we, fb_ack, retrace_start, retrace_irq;
  logic video_en, led_off, ok;
  logic [2:0]  board_num, irq_level;
  logic [19:0] host_addr;
  logic [15:0] host_wdata, host_rdata, fb_wdata, fb_wmask, fb_rdata, d, src;
  logic [9:0]  fb_x, fb_y;
  logic [31:0] rd_q[$], wr_q[$];  // Expected reads, expected writes
  int bad_count, n_checks, cyc;
  rbp_command_port DUT (.*);
  rbp_fb_model u_fb (.*);
  function automatic logic [19:0] mk(logic [2:0] b, logic u,
      logic [1:0] op, logic [1:0] pr, logic xy, logic [9:0] v);
    return {b, u, op, pr, xy, v, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hold the request until ack is sampled, then one clock more, then release it
  task automatic host_cmd(input logic w, input logic [19:0] a,
      input logic [15:0] dd, output logic got);
    int n;
    @(posedge clk);
    #1 {host_req, host_write, host_addr, host_wdata} = {1'b1, w, a, dd};
    got = 1'b0;
    for (n = 0; n < 40 && !got; n++) begin
      @(posedge clk);
      #1 got = (host_ack === 1'b1);
    end
    if (got) @(posedge clk);
    #1 host_req = 1'b0;
  endtask
  task automatic wait_idle;
    int n, q;
    q = 0;
    for (n = 0; n < 80 && q < 3; n++) begin
      @(posedge clk);
      #1 q = (fb_req === 1'b0) ? q + 1 : 0;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Result watchers take the oldest note off each queue
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish;
    end
    if (host_rdata_oe === 1'b1)
      chk("host_rdata", rd_q.size() ? rd_q.pop_front() : 32'hx, host_rdata);
    if (fb_req === 1'b1 && fb_we === 1'b1 && fb_ack === 1'b1)
      chk("fb_write", wr_q.size() ? wr_q.pop_front() : 32'hx, {fb_wmask, fb_wdata & fb_wmask});
  end
  initial begin
    {srst, ce, board_num, host_req, host_write} = {1'b1, 1'b1, BRD, 2'b00};
    {host_addr, host_wdata, retrace_start} = '0;
    void'($urandom(18));
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    chk("ctrl_rst", 5'h0, {irq_level, video_en, led_off});
    host_cmd(1'b1, mk(BRD, 0, OP_AUX, 0, 1, 10'(AUX_CTRL)), 16'he700, ok);
    wait_idle();
    chk("ctrl", 5'h1f, {irq_level, video_en, led_off});
    @(posedge clk);
    #1 retrace_start = 1'b1;
    @(posedge clk);
    #1 retrace_start = 1'b0;
    wait_idle();
    chk("irq_set", 1'b1, retrace_irq);
    host_cmd(1'b1, mk(BRD, 0, OP_AUX, 0, 1, 10'(AUX_IACK)), 16'h0, ok);
    wait_idle();
    chk("irq_clr", 1'b0, retrace_irq);
    for (int i = 0; i < 3; i++) begin
      d = 16'($urandom);
      src = (i == 1) ? src : d;
      host_cmd(1'b1, mk(BRD, 0, OP_AUX, 0, 1, 10'(AUX_FUNC)), {8'h3c, i == 0 ? 8'hcc : i == 1 ? 8'hf0 : 8'h00}, ok);
      host_cmd(1'b1, mk(BRD, 0, OP_AUX, 0, 1, 10'(AUX_WIDTH)), {12'habc, i == 2 ? 4'h4 : 4'h0}, ok);
      wr_q.push_back(i == 2 ? 32'hf0000000 : {16'hffff, d});
      host_cmd(1'b1, mk(BRD, 1, i == 1 ? OP_PAT : OP_SRC, 1, 0, 10'(16 * i + 16)), d, ok);
    end
    for (int i = 0; i < 4; i++) begin
      rd_q.push_back({16'h0, src});
      if (i != 2) src = {6'h0, 10'(80 + 16 * i)} ^ 16'ha5c3;
      host_cmd(1'b0, mk(BRD, 1, i == 0 ? OP_SRC : i == 1 ? OP_NONE : i == 2 ? OP_PAT : OP_AUX, 3, 0, 10'(80 + 16 * i)), 16'h0, ok);
      chk("ack", 1'b1, ok);
    end
    host_cmd(1'b0, mk(3'h4, 0, OP_SRC, 3, 0, 10'h0), 16'h0, ok);
    chk("other_board", 1'b0, ok);
    wait_idle();
    chk("queues", 32'h0, rd_q.size() + wr_q.size());
    tally_and_finish;
  end
endmodule
`default_nettype wire
